// *** rtl/pwt_pkg.sv ***
package pwt_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CONTROL0   = 8'h00;
   localparam logic [7:0] OFS_CONTROL1   = 8'h04;
   localparam logic [7:0] OFS_COUNTER    = 8'h08;
   localparam logic [7:0] OFS_PER_LOW    = 8'h0C;
   localparam logic [7:0] OFS_PER_HIGH   = 8'h10;
   localparam logic [7:0] OFS_STATUS     = 8'h14;
   localparam logic [7:0] OFS_PER_ACTIVE = 8'h18;

   // field positions
   localparam int MODE_LSB     = 0;
   localparam int PRE_LSB      = 2;
   localparam int POST_LSB     = 4;
   localparam int ON_BIT       = 7;
   localparam int DOWN_BIT     = 6;
   localparam int FLAG_BIT     = 0;

   // widths
   localparam int PER_W  = 12;
   localparam int PRE_W  = 6;
   localparam int POST_W = 4;

   // reset values
   localparam logic [1:0]        RST_MODE   = 2'h0;
   localparam logic [1:0]        RST_PRE    = 2'h0;
   localparam logic [POST_W-1:0] RST_POST   = 4'h0;
   localparam logic [PER_W-1:0]  RST_PERIOD = 12'h000;
   localparam logic [7:0]        RST_BUF_LO = 8'h00;
   localparam logic [3:0]        RST_BUF_HI = 4'h0;

   // last prescale count for ratios 1, 4, 16, 64
   localparam logic [PRE_W-1:0] PRE_LAST_1  = 6'h00;
   localparam logic [PRE_W-1:0] PRE_LAST_4  = 6'h03;
   localparam logic [PRE_W-1:0] PRE_LAST_16 = 6'h0F;
   localparam logic [PRE_W-1:0] PRE_LAST_64 = 6'h3F;

   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      mode_free,
      mode_single,
      mode_updown,
      mode_double
   } pwt_mode_t;
endpackage

// *** rtl/pwt_time_base.sv ***
// What this block does
// - free-running: event on each period match
// - free-running: counter wraps to zero after match
// - free-running: postscaler passes one of N matches
// - single-shot: one event at period match
// - single-shot: clear counter and enable after match
// - single-shot: postscaler ignored
// - up/down: event when counter reaches zero
// - up/down: postscaler thins zero events
// - double update: events at zero and period
// - period is twelve bits from two bytes
// - edge modes: load period at wrap
// - up/down modes: load period at zero
// - disabled: period loaded from buffer continuously
// - free-running period is (period+1) times prescale
// - up/down period is 2 times period times prescale
// - prescaler divides by 1, 4, 16, 64
// - four-bit postscaler, cleared by counter/control writes
// - up/down: count down after match, flag set
// - prescaler cleared by counter/control writes
`timescale 1ns/1ps
module pwt_time_base #(
   parameter int ADDR_W = 8
) (
   input  wire logic              i_sys_clk,       // 10 MHz clock
   input  wire logic              i_reset_n,       // async reset, active low
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,    // write address
   input  wire logic              s_axi_awvalid,   // write address valid
   output logic                   s_axi_awready,   // write address ready
   input  wire logic [31:0]       s_axi_wdata,     // write data
   input  wire logic [3:0]        s_axi_wstrb,     // write byte enables
   input  wire logic              s_axi_wvalid,    // write data valid
   output logic                   s_axi_wready,    // write data ready
   output logic [1:0]             s_axi_bresp,     // write response
   output logic                   s_axi_bvalid,    // write response valid
   input  wire logic              s_axi_bready,    // write response ready
   input  wire logic [ADDR_W-1:0] s_axi_araddr,    // read address
   input  wire logic              s_axi_arvalid,   // read address valid
   output logic                   s_axi_arready,   // read address ready
   output logic [31:0]            s_axi_rdata,     // read data
   output logic [1:0]             s_axi_rresp,     // read response
   output logic                   s_axi_rvalid,    // read data valid
   input  wire logic              s_axi_rready,    // read data ready
   output logic [11:0]            o_period_value,  // active period
   output logic [11:0]            o_counter,       // time base counter
   output logic                   o_count_down,    // counting down
   output logic                   o_time_base_on,  // time base enabled
   output logic                   o_event,         // one-cycle event pulse
   output logic                   o_event_flag     // sticky event flag
);

   typedef struct packed {
      pwt_pkg::pwt_mode_t        count_mode_sel;
      logic [1:0]                input_divide_sel;
      logic [3:0]                post_divide_sel;
      logic                      time_base_on;
      logic                      count_down_flag;
      logic [11:0]               time_base_counter;
      logic [11:0]               period_value;
      logic [7:0]                period_buffer_low;
      logic [3:0]                period_buffer_high;
      logic [5:0]                pre_cnt;
      logic [3:0]                post_cnt;
      logic                      flag;
      logic                      event_p;
      logic                      aw_got;
      logic [ADDR_W-1:0]         awaddr;
      logic                      w_got;
      logic [31:0]               wdata;
      logic [3:0]                wstrb;
      logic                      bvalid;
      logic [1:0]                bresp;
      logic                      rvalid;
      logic [31:0]               rdata;
      logic [1:0]                rresp;
   } pwt_state_t;

   pwt_state_t st;
   pwt_state_t next_st;

   logic        wr_fire;
   logic        wr_ctl;
   logic        wr_cnt;
   logic        wr_status;
   logic        tick;
   logic        ev;
   logic        raw_ev;
   logic        post_ok;
   logic [32:0] rd_word;
   logic [32:0] wr_word;

   function automatic logic [5:0] pre_last(input logic [1:0] sel);
      case (sel)
         2'h0:    pre_last = pwt_pkg::PRE_LAST_1;
         2'h1:    pre_last = pwt_pkg::PRE_LAST_4;
         2'h2:    pre_last = pwt_pkg::PRE_LAST_16;
         default: pre_last = pwt_pkg::PRE_LAST_64;
      endcase
   endfunction

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
      hit = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      merge = r;
   endfunction

   // {ok, data} for a read at address a
   function automatic logic [32:0] read_word(input pwt_state_t s, input logic [ADDR_W-1:0] a);
      logic [31:0] d;
      logic        ok;
      d  = 32'h0000_0000;
      ok = 1'b1;
      if (hit(a, pwt_pkg::OFS_CONTROL0)) begin
         d[pwt_pkg::MODE_LSB +: 2] = s.count_mode_sel;
         d[pwt_pkg::PRE_LSB +: 2]  = s.input_divide_sel;
         d[pwt_pkg::POST_LSB +: 4] = s.post_divide_sel;
      end else if (hit(a, pwt_pkg::OFS_CONTROL1)) begin
         d[pwt_pkg::ON_BIT]   = s.time_base_on;
         d[pwt_pkg::DOWN_BIT] = s.count_down_flag;
      end else if (hit(a, pwt_pkg::OFS_COUNTER)) begin
         d[11:0] = s.time_base_counter;
      end else if (hit(a, pwt_pkg::OFS_PER_LOW)) begin
         d[7:0] = s.period_buffer_low;
      end else if (hit(a, pwt_pkg::OFS_PER_HIGH)) begin
         d[3:0] = s.period_buffer_high;
      end else if (hit(a, pwt_pkg::OFS_STATUS)) begin
         d[pwt_pkg::FLAG_BIT] = s.flag;
      end else if (hit(a, pwt_pkg::OFS_PER_ACTIVE)) begin
         d[11:0] = s.period_value;
      end else begin
         ok = 1'b0;
      end
      read_word = {ok, d};
   endfunction

   assign s_axi_awready  = !st.aw_got && !st.bvalid;
   assign s_axi_wready   = !st.w_got && !st.bvalid;
   assign s_axi_bvalid   = st.bvalid;
   assign s_axi_bresp    = st.bresp;
   assign s_axi_arready  = !st.rvalid;
   assign s_axi_rvalid   = st.rvalid;
   assign s_axi_rdata    = st.rdata;
   assign s_axi_rresp    = st.rresp;
   assign o_period_value = st.period_value;
   assign o_counter      = st.time_base_counter;
   assign o_count_down   = st.count_down_flag;
   assign o_time_base_on = st.time_base_on;
   assign o_event        = st.event_p;
   assign o_event_flag   = st.flag;

   assign wr_fire   = st.aw_got && st.w_got && !st.bvalid;
   assign wr_ctl    = wr_fire && (hit(st.awaddr, pwt_pkg::OFS_CONTROL0) || hit(st.awaddr, pwt_pkg::OFS_CONTROL1));
   assign wr_cnt    = wr_fire && hit(st.awaddr, pwt_pkg::OFS_COUNTER);
   assign wr_status = wr_fire && hit(st.awaddr, pwt_pkg::OFS_STATUS) && st.wstrb[0]
                      && st.wdata[pwt_pkg::FLAG_BIT];
   assign tick      = st.time_base_on && (st.pre_cnt == pre_last(st.input_divide_sel));
   assign post_ok   = (st.post_cnt == st.post_divide_sel);
   assign rd_word   = read_word(st, s_axi_araddr);
   assign wr_word   = read_word(st, st.awaddr);

   always_comb begin
      logic [31:0] m;
      logic        updown;
      m       = 32'h0000_0000;
      updown  = 1'b0;
      next_st = st;
      raw_ev  = 1'b0;
      ev      = 1'b0;
      next_st.event_p = 1'b0;

      // bus channels
      if (s_axi_awvalid && s_axi_awready) begin
         next_st.aw_got = 1'b1;
         next_st.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_st.w_got = 1'b1;
         next_st.wdata = s_axi_wdata;
         next_st.wstrb = s_axi_wstrb;
      end
      if (st.bvalid && s_axi_bready) begin
         next_st.bvalid = 1'b0;
      end
      if (st.rvalid && s_axi_rready) begin
         next_st.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_st.rvalid = 1'b1;
         next_st.rdata  = rd_word[31:0];
         next_st.rresp  = rd_word[32] ? pwt_pkg::RESP_OKAY : pwt_pkg::RESP_SLVERR;
      end

      // time base
      updown = (st.count_mode_sel == pwt_pkg::mode_updown) || (st.count_mode_sel == pwt_pkg::mode_double);
      if (!st.time_base_on) begin
         next_st.pre_cnt = 6'h00;
      end else if (tick) begin
         next_st.pre_cnt = 6'h00;
      end else begin
         next_st.pre_cnt = st.pre_cnt + 6'h01;
      end

      if (tick) begin
         if (!updown) begin
            if (st.time_base_counter == st.period_value) begin
               raw_ev = 1'b1;
               next_st.time_base_counter = 12'h000;
               next_st.period_value = {st.period_buffer_high, st.period_buffer_low};
               if (st.count_mode_sel == pwt_pkg::mode_single) begin
                  next_st.time_base_on = 1'b0;
               end
            end else begin
               next_st.time_base_counter = st.time_base_counter + 12'h001;
            end
         end else if (st.time_base_counter == 12'h000) begin
            raw_ev = 1'b1;
            next_st.period_value = {st.period_buffer_high, st.period_buffer_low};
            next_st.count_down_flag = 1'b0;
            next_st.time_base_counter = (next_st.period_value == 12'h000) ? 12'h000 : 12'h001;
         end else if (!st.count_down_flag && st.time_base_counter == st.period_value) begin
            raw_ev = (st.count_mode_sel == pwt_pkg::mode_double);
            next_st.count_down_flag = 1'b1;
            next_st.time_base_counter = st.time_base_counter - 12'h001;
         end else if (st.count_down_flag) begin
            next_st.time_base_counter = st.time_base_counter - 12'h001;
         end else begin
            next_st.time_base_counter = st.time_base_counter + 12'h001;
         end
      end

      // single and double modes pass every event; others go through the postscaler
      if (raw_ev) begin
         if (st.count_mode_sel == pwt_pkg::mode_single || st.count_mode_sel == pwt_pkg::mode_double) begin
            ev = 1'b1;
         end else if (post_ok) begin
            ev = 1'b1;
            next_st.post_cnt = 4'h0;
         end else begin
            next_st.post_cnt = st.post_cnt + 4'h1;
         end
      end
      next_st.event_p = ev;

      // register writes; the mode is expected to change only while disabled
      if (wr_fire) begin
         next_st.aw_got = 1'b0;
         next_st.w_got  = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp  = wr_word[32] ? pwt_pkg::RESP_OKAY : pwt_pkg::RESP_SLVERR;
         if (hit(st.awaddr, pwt_pkg::OFS_CONTROL0)) begin
            m = merge({24'h000000, st.post_divide_sel, st.input_divide_sel, st.count_mode_sel},
                      st.wdata, st.wstrb);
            next_st.count_mode_sel   = pwt_pkg::pwt_mode_t'(m[pwt_pkg::MODE_LSB +: 2]);
            next_st.input_divide_sel = m[pwt_pkg::PRE_LSB +: 2];
            next_st.post_divide_sel  = m[pwt_pkg::POST_LSB +: 4];
         end
         if (hit(st.awaddr, pwt_pkg::OFS_CONTROL1) && st.wstrb[0]) begin
            next_st.time_base_on = st.wdata[pwt_pkg::ON_BIT];
         end
         if (hit(st.awaddr, pwt_pkg::OFS_COUNTER)) begin
            m = merge({20'h00000, st.time_base_counter}, st.wdata, st.wstrb);
            next_st.time_base_counter = m[11:0];
         end
         if (hit(st.awaddr, pwt_pkg::OFS_PER_LOW) && st.wstrb[0]) begin
            next_st.period_buffer_low = st.wdata[7:0];
         end
         if (hit(st.awaddr, pwt_pkg::OFS_PER_HIGH) && st.wstrb[0]) begin
            next_st.period_buffer_high = st.wdata[3:0];
         end
      end
      if (wr_ctl || wr_cnt) begin
         next_st.pre_cnt  = 6'h00;
         next_st.post_cnt = 4'h0;
      end

      // set wins over the software clear
      if (wr_status) begin
         next_st.flag = 1'b0;
      end
      if (ev) begin
         next_st.flag = 1'b1;
      end

      if (!st.time_base_on) begin
         next_st.period_value = {st.period_buffer_high, st.period_buffer_low};
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st                  <= '0;
         st.count_mode_sel   <= pwt_pkg::pwt_mode_t'(pwt_pkg::RST_MODE);
         st.input_divide_sel <= pwt_pkg::RST_PRE;
         st.post_divide_sel  <= pwt_pkg::RST_POST;
         st.period_value     <= pwt_pkg::RST_PERIOD;
         st.period_buffer_low  <= pwt_pkg::RST_BUF_LO;
         st.period_buffer_high <= pwt_pkg::RST_BUF_HI;
      end else begin
         st <= next_st;
      end
   end

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_reset_n);

   logic quiet;
   assign quiet = !wr_fire;

   a_free_wrap: assert property (quiet && tick && st.count_mode_sel == pwt_pkg::mode_free
      && st.time_base_counter == st.period_value |=> st.time_base_counter == 12'h000)
      else $error("free-running counter did not wrap");
   a_single_stop: assert property (quiet && tick && st.count_mode_sel == pwt_pkg::mode_single
      && st.time_base_counter == st.period_value |=> !st.time_base_on && st.time_base_counter == 12'h000)
      else $error("single-shot did not halt");
   a_single_event: assert property (quiet && tick && st.count_mode_sel == pwt_pkg::mode_single
      && st.time_base_counter == st.period_value |=> o_event ##1 !o_event)
      else $error("single-shot event missing");
   a_updown_turn: assert property (quiet && tick && st.count_mode_sel == pwt_pkg::mode_updown
      && !st.count_down_flag && st.time_base_counter == st.period_value && st.period_value != 12'h000
      |=> st.count_down_flag && st.time_base_counter == $past(st.period_value) - 12'h001)
      else $error("up/down did not turn down");
   a_double_event: assert property (tick && st.count_mode_sel == pwt_pkg::mode_double
      && !st.count_down_flag && st.time_base_counter == st.period_value |=> o_event)
      else $error("double update event missing at period");
   a_zero_event: assert property (tick && st.count_mode_sel == pwt_pkg::mode_updown
      && st.time_base_counter == 12'h000 && st.post_divide_sel == 4'h0 |=> o_event && o_event_flag)
      else $error("zero event missing");
   a_off_load: assert property (!st.time_base_on |=>
      st.period_value == {$past(st.period_buffer_high), $past(st.period_buffer_low)})
      else $error("period not loaded while disabled");
   a_flag_sticky: assert property (o_event_flag && !wr_status |=> o_event_flag)
      else $error("event flag lost");
   a_post_gap: assert property (o_event && st.count_mode_sel == pwt_pkg::mode_free
      && st.post_divide_sel != 4'h0 && !wr_ctl && !wr_cnt |=> !o_event)
      else $error("postscaler passed events too often");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");

   c_single_done: cover property (st.time_base_on ##1 !st.time_base_on && st.count_mode_sel == pwt_pkg::mode_single);
   c_double_ev: cover property (o_event && st.count_mode_sel == pwt_pkg::mode_double && st.count_down_flag);
   c_post_ev: cover property (o_event && st.count_mode_sel == pwt_pkg::mode_free && st.post_divide_sel != 4'h0);
   c_flag_race: cover property (ev && wr_status);

endmodule // pwt_time_base

// *** rtl/pwt_fix_note.sv ***
`timescale 1ns/1ps

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
   logic        i_sys_clk, i_reset_n;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [11:0] o_period_value, o_counter;
   logic        o_count_down, o_time_base_on, o_event, o_event_flag;
   int          mismatches, checks_done, g, p, pr, po;
   logic        saw_down;
   logic [31:0] d;
   logic [1:0]  r;

   pwt_time_base dut (
      .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .o_period_value(o_period_value),
      .o_counter(o_counter), .o_count_down(o_count_down), .o_time_base_on(o_time_base_on),
      .o_event(o_event), .o_event_flag(o_event_flag)
   );

   initial begin
      i_sys_clk = 1'b0;
      forever #50 i_sys_clk = ~i_sys_clk;
   end

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic chk_gap(input string nm, input int exp, input int got);
      checks_done++;
      if (got != exp) begin
         mismatches++;
         $display("unexpected %s expected %0d seen %0d", nm, exp, got);
      end
   endtask

   task automatic results();
      $display("counts: checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // one write; address and data released each at its own acceptance edge
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] dv, output logic [1:0] resp);
      int   n;
      logic ta, tw, got;
      n = 0;
      got = 1'b0;
      resp = 2'h3;
      @(posedge i_sys_clk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= dv;
      s_axi_wstrb   <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      while (!got && n < 200) begin
         @(negedge i_sys_clk);
         ta = s_axi_awvalid & s_axi_awready;
         tw = s_axi_wvalid & s_axi_wready;
         got = s_axi_bvalid;
         if (got) resp = s_axi_bresp;
         @(posedge i_sys_clk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         n++;
      end
      s_axi_bready <= 1'b0;
      chk("write answered", 32'h1, {31'h0, got});
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] resp);
      int   n;
      logic ta, got;
      n = 0;
      got = 1'b0;
      @(posedge i_sys_clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      while (!got && n < 200) begin
         @(negedge i_sys_clk);
         ta = s_axi_arvalid & s_axi_arready;
         got = s_axi_rvalid;
         dv = s_axi_rdata;
         resp = s_axi_rresp;
         @(posedge i_sys_clk);
         if (ta) s_axi_arvalid <= 1'b0;
         n++;
      end
      s_axi_rready <= 1'b0;
      chk("read answered", 32'h1, {31'h0, got});
   endtask

   task automatic wr_ok(input logic [7:0] a, input logic [31:0] dv);
      logic [1:0] rs;
      axi_wr(a, dv, rs);
      chk("write resp", {30'h0, pwt_pkg::RESP_OKAY}, {30'h0, rs});
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string nm);
      logic [31:0] dv;
      logic [1:0]  rs;
      axi_rd(a, dv, rs);
      chk(nm, exp, dv);
   endtask

   // cycles between the next two event pulses
   task automatic gap(output int c);
      int n;
      c = 0;
      n = 0;
      @(negedge i_sys_clk);
      while (o_event !== 1'b1 && n < 6000) begin
         @(negedge i_sys_clk);
         n++;
      end
      do begin
         @(negedge i_sys_clk);
         c++;
         if (o_count_down === 1'b1) saw_down = 1'b1;
      end while (o_event !== 1'b1 && c < 6000);
   endtask

   function automatic int ratio(input int code);
      return 1 << (2 * code);
   endfunction

   task automatic cfg(input int md, input int pre, input int post, input int per);
      wr_ok(pwt_pkg::OFS_CONTROL1, 32'h0);
      wr_ok(pwt_pkg::OFS_COUNTER, 32'h0);
      wr_ok(pwt_pkg::OFS_CONTROL0, (post << 4) | (pre << 2) | md);
      wr_ok(pwt_pkg::OFS_PER_LOW, per & 8'hFF);
      wr_ok(pwt_pkg::OFS_PER_HIGH, 32'hA0 | ((per >> 8) & 4'hF));
      rd_chk(pwt_pkg::OFS_PER_HIGH, (per >> 8) & 4'hF, "period high");
      rd_chk(pwt_pkg::OFS_PER_ACTIVE, per, "active period");
      wr_ok(pwt_pkg::OFS_CONTROL1, 32'h80);
      saw_down = 1'b0;
   endtask

   initial begin
      i_reset_n = 1'b0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      void'($urandom(55707));
      repeat (6) @(posedge i_sys_clk);
      i_reset_n <= 1'b1;
      for (int i = 0; i < 7; i++) rd_chk(8'(4 * i), 32'h0, "reset value");
      axi_rd(8'h1C, d, r);
      chk("unmapped read", {30'h0, pwt_pkg::RESP_SLVERR}, {30'h0, r});
      axi_wr(8'h1C, 32'h5, r);
      chk("unmapped write", {30'h0, pwt_pkg::RESP_SLVERR}, {30'h0, r});
      $display("test registers done");
      for (int k = 0; k < 4; k++) begin
         p = 2 + $urandom % 8;
         po = (k == 0) ? 3 : $urandom % 4;
         cfg(0, k, po, p);
         gap(g);
         gap(g);
         chk_gap("free gap", (po + 1) * (p + 1) * ratio(k), g);
      end
      rd_chk(pwt_pkg::OFS_STATUS, 32'h1, "flag set");
      chk("flag pin", 32'h1, {31'h0, o_event_flag});
      wr_ok(pwt_pkg::OFS_CONTROL1, 32'h0);
      wr_ok(pwt_pkg::OFS_STATUS, 32'h1);
      rd_chk(pwt_pkg::OFS_STATUS, 32'h0, "flag cleared");
      chk("flag pin cleared", 32'h0, {31'h0, o_event_flag});
      $display("test free running done");
      p = 2 + $urandom % 8;
      pr = $urandom % 4;
      cfg(1, pr, 3, p);
      g = 0;
      while (o_event !== 1'b1 && g < (p + 2) * ratio(pr) + 20) begin
         @(negedge i_sys_clk);
         g++;
      end
      chk("single event", 32'h1, {31'h0, o_event});
      repeat (3) @(negedge i_sys_clk);
      chk("single enable", 32'h0, {31'h0, o_time_base_on});
      chk("single counter", 32'h0, {20'h0, o_counter});
      g = 0;
      repeat (300) begin
         @(negedge i_sys_clk);
         if (o_event !== 1'b0) g++;
      end
      chk_gap("single extra events", 0, g);
      $display("test single shot done");
      for (int m = 2; m < 4; m++) begin
         p = 2 + $urandom % 8;
         pr = $urandom % 4;
         po = $urandom % 4;
         cfg(m, pr, po, p);
         gap(g);
         gap(g);
         if (m == 2) chk_gap("updown gap", (po + 1) * 2 * p * ratio(pr), g);
         else chk_gap("double gap", p * ratio(pr), g);
         chk("count down seen", 32'h1, {31'h0, saw_down});
      end
      $display("test up down done");
      for (int m = 0; m < 3; m += 2) begin
         p = 2 + $urandom % 8;
         cfg(m, 0, 0, p);
         gap(g);
         wr_ok(pwt_pkg::OFS_PER_LOW, p + 3);
         gap(g);
         gap(g);
         chk_gap("new period gap", (m == 0) ? p + 4 : 2 * (p + 3), g);
         chk("period pin", p + 3, {20'h0, o_period_value});
      end
      $display("test period update done");
      results();
   end

   initial begin
      repeat (90000) @(posedge i_sys_clk);
      mismatches++;
      $display("unexpected watchdog expected finish seen hang");
      results();
   end
endmodule // tb_top
